//--- core/rtf_frame_ctrl.sv
/*
  RTU frame transfer control: receive byte storage into swapped buffers,
  frame silence timer with two compares, transmit byte feeding with
  appended check value, line driver turnaround and response policy.
  Assumes a serial port that raises one-cycle receive, transmit-ready and
  transmit-end pulses synchronous to pclk, and an APB master.
*/
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// - Each received byte stored up to buffer depth, silence timer restarted
// - Receive path runs without software per byte
// - Compare A: stop, save count, swap, clear
// - Software reads and clears saved count, processes
// - Start: driver on, receiver off, load, start
// - One byte per transmit request until count done
// - After last byte: enable end, disable requests
// - End event: restart timer on compare B only
// - Compare B: stop, driver off, back to A
// - Good self-addressed frame gets a response
// - Foreign address frame stored and counted, no response
// - Self-addressed frame with bad check: silent
// - Check value: CRC16, LSB first, FFFF, uninverted
module rtf_frame_ctrl
  import rtf_pkg::*;
#(
  parameter int BUF_AW = 8
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial port, receive side
  input  wire logic        receive_byte_request,
  input  wire logic [7:0]  rx_byte,
  // Serial port, transmit side
  input  wire logic        transmit_ready_request,
  input  wire logic        transmit_end_event,
  output logic      [7:0]  tx_byte,
  output logic             tx_byte_load,
  output logic             serial_tx_enable,
  output logic             transmit_ready_enable,
  output logic             transmit_end_enable,
  // Line transceiver
  output logic             line_driver_enable,
  output logic             receiver_enable_n
);

  localparam logic [8:0] DEPTH = 9'(2**BUF_AW);

  // Buffer windows hold 256 words, so deeper buffers cannot be reached
  if (BUF_AW < 2 || BUF_AW > 8) begin : g_chk
    $error("rtf_frame_ctrl: BUF_AW must be 2..8");
  end

  typedef enum logic [2:0] {TX_IDLE, TX_FETCH, TX_SEND, TX_WAIT_END, TX_TURN} rtf_tx_state_e;

  // Register word decode, shared by read mux and error answer
  function automatic logic is_mapped(input logic [11:0] a);
    return (a[11:10] == WIN_RX) || (a[11:10] == WIN_TX) ||
           (a[11:5] == 7'h00);
  endfunction

  // Byte of the exception answer at a given position
  function automatic logic [7:0] exc_byte(input logic [8:0] pos, input logic [7:0] adr,
                                          input logic [7:0] fn);
    case (pos[1:0])
      2'h0:    return adr;
      2'h1:    return fn | EXC_FLAG;
      default: return EXC_ILLEGAL_FN;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]        station;
  logic [15:0]       sil_a;
  logic [15:0]       sil_b;
  logic [31:0]       func_mask;
  logic [8:0]        tx_len;
  logic [15:0]       tmr_cnt;
  logic [5:0]        div_cnt;
  logic              tmr_run;
  logic              cmp_a_en;
  logic              cmp_b_en;
  logic              tick;
  logic              rx_take;
  logic              match_a;
  logic              match_b;
  logic              tei_take;
  logic              rx_bank;
  logic [8:0]        rx_cnt;
  logic [15:0]       rx_crc;
  logic [7:0]        rx_addr;
  logic [7:0]        rx_func;
  logic              overrun;
  logic [8:0]        saved_cnt;
  logic              frame_ready;
  rtf_verdict_e      verdict;
  rtf_verdict_e      next_verdict;
  rtf_tx_state_e     tx_state;
  logic [8:0]        tx_ptr;
  logic [8:0]        tx_frame_len;
  logic [15:0]       tx_crc;
  logic              tx_exc;
  logic [7:0]        exc_addr;
  logic [7:0]        exc_func;
  logic              tx_pend;
  logic [7:0]        tx_src;
  logic              sw_start;
  logic              exc_start;
  logic              tx_go;
  logic              apb_acc;
  logic              wr_fire;
  logic              rd_fire;
  logic [7:0]        rx_mem_q;
  logic [7:0]        tx_mem_q;
  logic [31:0]       rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Bus strobes: writes and read side effects land on the completing edge
  assign apb_acc = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite;
  assign rd_fire = psel & penable & pready & ~pwrite;

  // Event qualifiers; receiver is disabled while the driver is on
  assign rx_take  = receive_byte_request & ~line_driver_enable;
  assign match_a  = tmr_run & cmp_a_en & (tmr_cnt == sil_a) & ~rx_take;
  assign match_b  = tmr_run & cmp_b_en & (tmr_cnt == sil_b);
  assign tei_take = transmit_end_event & transmit_end_enable & (tx_state == TX_WAIT_END);
  assign tick     = (div_cnt == 6'(TICK_CYCLES - 1));

  // Only a good self-addressed query may be answered by software
  assign sw_start  = wr_fire & (paddr == OFS_CTRL) & pwdata[CTRL_TX_START] &
                     (verdict == VD_NORMAL) & (tx_state == TX_IDLE);
  assign exc_start = match_a & (next_verdict == VD_UNSUP);
  assign tx_go     = sw_start | exc_start;

  ////////////////////////////////////////////////////////////////////////////
  // Buffers: two receive banks side by side, one transmit buffer
  rtf_ram #(.AW(BUF_AW + 1), .DW(8)) u_rx_ram (
    .clk   (pclk),
    .rst_n (presetn),
    .we    (rx_take & (rx_cnt < DEPTH)),
    .waddr ({rx_bank, rx_cnt[BUF_AW-1:0]}),
    .wdata (rx_byte),
    .raddr ({~rx_bank, paddr[BUF_AW+1:2]}),
    .rdata (rx_mem_q)
  );

  rtf_ram #(.AW(BUF_AW), .DW(8)) u_tx_ram (
    .clk   (pclk),
    .rst_n (presetn),
    .we    (wr_fire & (paddr[11:10] == WIN_TX) & ((paddr[9:2] >> BUF_AW) == 8'h00)),
    .waddr (paddr[BUF_AW+1:2]),
    .wdata (pwdata[7:0]),
    .raddr (tx_ptr[BUF_AW-1:0]),
    .rdata (tx_mem_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station   <= STATION_RST;
      sil_a     <= SIL_A_RST;
      sil_b     <= SIL_B_RST;
      func_mask <= FUNC_MASK_RST;
      tx_len    <= TX_LEN_RST;
    end else if (wr_fire) begin
      case (paddr)
        OFS_STATION:   station   <= pwdata[7:0];
        OFS_SIL_A:     sil_a     <= pwdata[15:0];
        OFS_SIL_B:     sil_b     <= pwdata[15:0];
        OFS_FUNC_MASK: func_mask <= pwdata;
        OFS_TX_LEN:    tx_len    <= pwdata[8:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Silence timer: 1 us ticks from a divider, two compares
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_cnt <= '0;
      div_cnt <= '0;
      tmr_run <= 1'b0;
    end else if (rx_take) begin
      tmr_cnt <= '0;
      div_cnt <= '0;
      tmr_run <= 1'b1;
    end else if (match_a) begin
      tmr_run <= 1'b0;
    end else if (tei_take) begin
      tmr_cnt <= '0;
      div_cnt <= '0;
      tmr_run <= 1'b1;
    end else if (match_b) begin
      tmr_run <= 1'b0;
    end else if (tmr_run) begin
      div_cnt <= tick ? '0 : div_cnt + 6'h01;
      if (tick) begin
        tmr_cnt <= tmr_cnt + 16'h0001;
      end
    end
  end

  // Compare enables swap between end-of-frame and turnaround duty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_a_en <= 1'b1;
      cmp_b_en <= 1'b0;
    end else if (tei_take) begin
      cmp_a_en <= 1'b0;
      cmp_b_en <= 1'b1;
    end else if (match_b) begin
      cmp_b_en <= 1'b0;
      cmp_a_en <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame classification from address, check residue and function mask
  always_comb begin
    next_verdict = VD_NONE;
    if (rx_cnt == '0) begin
      next_verdict = VD_NONE;
    end else if (rx_addr != station && rx_addr != BROADCAST_ADDR) begin
      next_verdict = VD_OTHER;
    end else if (rx_cnt < MIN_FRAME || rx_crc != '0 || overrun) begin
      next_verdict = VD_CRC_ERR;
    end else if (rx_addr == BROADCAST_ADDR) begin
      next_verdict = VD_BCAST;
    end else if (rx_func[7:5] != 3'h0 || !func_mask[rx_func[4:0]]) begin
      next_verdict = VD_UNSUP;
    end else begin
      next_verdict = VD_NORMAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive engine: byte store, running check value, end of frame.
  // Software only ever sees finished frames in the idle bank.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_bank <= 1'b0;
      rx_cnt  <= '0;
      rx_crc  <= CRC_INIT;
      rx_addr <= '0;
      rx_func <= '0;
      overrun <= 1'b0;
    end else if (match_a) begin
      rx_bank <= ~rx_bank;
      rx_cnt  <= '0;
      rx_crc  <= CRC_INIT;
      overrun <= 1'b0;
    end else if (rx_take) begin
      rx_crc <= rtf_crc_byte(rx_crc, rx_byte);
      if (rx_cnt == 9'h000) begin
        rx_addr <= rx_byte;
      end
      if (rx_cnt == 9'h001) begin
        rx_func <= rx_byte;
      end
      if (rx_cnt < DEPTH) begin
        rx_cnt <= rx_cnt + 9'h001;
      end else begin
        overrun <= 1'b1;             // Excess bytes dropped, frame marked bad
      end
    end
  end

  // Saved count and verdict; a new frame end wins over the clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_cnt   <= '0;
      frame_ready <= 1'b0;
      verdict     <= VD_NONE;
    end else if (match_a) begin
      saved_cnt   <= rx_cnt;
      frame_ready <= (rx_cnt != '0);
      verdict     <= next_verdict;
    end else begin
      if (rd_fire && paddr == OFS_RX_COUNT) begin
        saved_cnt   <= '0;
        frame_ready <= 1'b0;
      end
      if (sw_start) begin
        verdict <= VD_NONE;          // One answer per query
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit byte source: buffer or exception bytes, then check value
  always_comb begin
    if (tx_ptr < tx_frame_len) begin
      tx_src = tx_exc ? exc_byte(tx_ptr, exc_addr, exc_func) : tx_mem_q;
    end else if (tx_ptr == tx_frame_len) begin
      tx_src = tx_crc[7:0];
    end else begin
      tx_src = tx_crc[15:8];
    end
  end

  // Pending transmit-ready request, held while the buffer read settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pend <= 1'b0;
    end else if (transmit_ready_request && transmit_ready_enable) begin
      tx_pend <= 1'b1;
    end else if (tx_state == TX_SEND) begin
      tx_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit sequencer and line turnaround
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state              <= TX_IDLE;
      tx_ptr                <= '0;
      tx_frame_len          <= '0;
      tx_crc                <= CRC_INIT;
      tx_exc                <= 1'b0;
      exc_addr              <= '0;
      exc_func              <= '0;
      tx_byte               <= '0;
      tx_byte_load          <= 1'b0;
      serial_tx_enable      <= 1'b0;
      transmit_ready_enable <= 1'b0;
      transmit_end_enable   <= 1'b0;
      line_driver_enable    <= 1'b0;
      receiver_enable_n     <= 1'b0;
    end else begin
      tx_byte_load <= 1'b0;
      case (tx_state)
        TX_IDLE: begin
          if (tx_go) begin
            line_driver_enable    <= 1'b1;
            receiver_enable_n     <= 1'b1;
            tx_ptr                <= '0;
            tx_frame_len          <= exc_start ? EXC_LEN :
                                     ((tx_len > DEPTH) ? DEPTH : tx_len);
            tx_exc                <= exc_start;
            exc_addr              <= rx_addr;
            exc_func              <= rx_func;
            tx_crc                <= CRC_INIT;
            serial_tx_enable      <= 1'b1;
            transmit_ready_enable <= 1'b1;
            tx_state              <= TX_FETCH;
          end
        end
        TX_FETCH: begin
          tx_state <= TX_SEND;       // Buffer read data valid next cycle
        end
        TX_SEND: begin
          if (tx_pend) begin
            if (tx_ptr != tx_frame_len + CRC_BYTES) begin
              tx_byte      <= tx_src;
              tx_byte_load <= 1'b1;
              if (tx_ptr < tx_frame_len) begin
                tx_crc <= rtf_crc_byte(tx_crc, tx_src);
              end
              tx_ptr   <= tx_ptr + 9'h001;
              tx_state <= TX_FETCH;
            end else begin
              transmit_end_enable   <= 1'b1;
              transmit_ready_enable <= 1'b0;
              tx_state              <= TX_WAIT_END;
            end
          end
        end
        TX_WAIT_END: begin
          if (tei_take) begin
            transmit_end_enable <= 1'b0;
            tx_state            <= TX_TURN;
          end
        end
        TX_TURN: begin
          if (match_b) begin
            line_driver_enable <= 1'b0;
            receiver_enable_n  <= 1'b0;
            serial_tx_enable   <= 1'b0;
            tx_state           <= TX_IDLE;
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    rd_mux = '0;
    if (paddr[11:10] == WIN_RX) begin
      rd_mux = {24'h0, rx_mem_q};
    end else begin
      case (paddr)
        OFS_STATION:   rd_mux = {24'h0, station};
        OFS_SIL_A:     rd_mux = {16'h0, sil_a};
        OFS_SIL_B:     rd_mux = {16'h0, sil_b};
        OFS_FUNC_MASK: rd_mux = func_mask;
        OFS_TX_LEN:    rd_mux = {23'h0, tx_len};
        OFS_RX_COUNT: begin
          rd_mux            = {23'h0, saved_cnt};
          rd_mux[RXC_READY] = frame_ready;
        end
        OFS_STATUS: begin
          rd_mux[2:0]          = verdict;
          rd_mux[STAT_DRIVER]  = line_driver_enable;
          rd_mux[STAT_BANK]    = rx_bank;
          rd_mux[STAT_OVERRUN] = overrun;
          rd_mux[STAT_TX_BUSY] = (tx_state != TX_IDLE);
        end
        default: rd_mux = '0;
      endcase
    end
  end

  // APB answer: one wait state so buffer reads come from registered memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apb_acc;
      pslverr <= apb_acc & ~is_mapped(paddr);
      if (apb_acc && !pwrite) begin
        prdata <= is_mapped(paddr) ? rd_mux : '0;
      end
    end
  end

endmodule

//--- core/rtf_pkg.sv
/*
  Shared constants for the RTU frame transfer control block: register map,
  reset values, frame constants, timing and the check-value function.
  Assumes a single 40 MHz peripheral clock and a 32-bit APB register bus.
*/
package rtf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and silence timer tick
  localparam int CLK_HZ       = 40_000_000;
  localparam int CLK_PERIOD_PS = 1_000_000_000 / (CLK_HZ / 1000);
  localparam int TICK_NS      = 1000;
  // Timer tick of 1 us, expressed in clock cycles
  localparam int TICK_CYCLES  = (TICK_NS * 1000) / CLK_PERIOD_PS;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_STATION   = 12'h004;
  localparam logic [11:0] OFS_SIL_A     = 12'h008;
  localparam logic [11:0] OFS_SIL_B     = 12'h00c;
  localparam logic [11:0] OFS_FUNC_MASK = 12'h010;
  localparam logic [11:0] OFS_TX_LEN    = 12'h014;
  localparam logic [11:0] OFS_RX_COUNT  = 12'h018;
  localparam logic [11:0] OFS_STATUS    = 12'h01c;
  // Buffer windows: one word per byte, selected by the top two address bits
  localparam logic [1:0]  WIN_RX        = 2'h1;
  localparam logic [1:0]  WIN_TX        = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_TX_START   = 0;
  localparam int STAT_DRIVER     = 3;
  localparam int STAT_BANK       = 4;
  localparam int STAT_OVERRUN    = 5;
  localparam int STAT_TX_BUSY    = 6;
  localparam int RXC_READY       = 31;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values (timer compares are in 1 us ticks)
  localparam logic [7:0]  STATION_RST   = 8'h01;
  localparam logic [15:0] SIL_A_RST     = 16'h0faa;
  localparam logic [15:0] SIL_B_RST     = 16'h0032;
  localparam logic [31:0] FUNC_MASK_RST = 32'h0000_0000;
  localparam logic [8:0]  TX_LEN_RST    = 9'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Frame constants
  localparam logic [7:0]  BROADCAST_ADDR = 8'h00;
  localparam logic [7:0]  EXC_FLAG       = 8'h80;
  localparam logic [7:0]  EXC_ILLEGAL_FN = 8'h01;
  localparam logic [8:0]  EXC_LEN        = 9'h003;
  localparam logic [8:0]  MIN_FRAME      = 9'h004;
  localparam logic [8:0]  CRC_BYTES      = 9'h002;
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [15:0] CRC_POLY_REFL  = 16'ha001;

  // Outcome of one received frame
  typedef enum logic [2:0] {
    VD_NONE, VD_OTHER, VD_BCAST, VD_CRC_ERR, VD_UNSUP, VD_NORMAL
  } rtf_verdict_e;

  // One byte into the 16-bit check value, LSB first, result not inverted
  function automatic logic [15:0] rtf_crc_byte(input logic [15:0] crc,
                                               input logic [7:0]  data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction

endpackage

//--- core/rtf_ram.sv
/*
  Small byte memory with one write port and one registered read port.
  Assumes writer and reader share the clock; read data lag the address by
  one edge.
*/
`timescale 1ns/1ps
module rtf_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];

  if (AW < 1 || DW < 1) begin : g_chk
    $error("rtf_ram: AW and DW must be positive");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array write, no reset so it maps onto block memory
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

//--- testbench/rtf_frame_chk.sv
/* Port checker for the frame transfer control block.
   Assumes pclk, presetn and the transmit pins of the top module. */
`timescale 1ns/1ps
module rtf_frame_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Transmit side and transceiver
  input wire logic transmit_end_event,
  input wire logic tx_byte_load,
  input wire logic serial_tx_enable,
  input wire logic transmit_ready_enable,
  input wire logic transmit_end_enable,
  input wire logic line_driver_enable,
  input wire logic receiver_enable_n
);
  // One clock domain, so a single default
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  property p_pair; line_driver_enable == receiver_enable_n; endproperty
  a_pair: assert property (p_pair)
    else $error("driver and receiver enables differ");
  property p_start;
    $rose(serial_tx_enable) |-> line_driver_enable && transmit_ready_enable;
  endproperty
  a_start: assert property (p_start)
    else $error("transmit started without driver");
  property p_load; tx_byte_load |-> line_driver_enable && transmit_ready_enable; endproperty
  a_load: assert property (p_load)
    else $error("byte loaded outside transmit");
  property p_once; tx_byte_load |=> !tx_byte_load; endproperty
  a_once: assert property (p_once)
    else $error("two loads for one request");
  property p_last;
    $rose(transmit_end_enable) |-> !transmit_ready_enable && line_driver_enable;
  endproperty
  a_last: assert property (p_last)
    else $error("end enabled with requests on");
  property p_end;
    transmit_end_enable && transmit_end_event |=>
      (!transmit_end_enable && line_driver_enable) [*8];
  endproperty
  a_end: assert property (p_end)
    else $error("end event not taken or driver dropped early");
  property p_turn;
    $fell(line_driver_enable) |-> !serial_tx_enable && !transmit_end_enable;
  endproperty
  a_turn: assert property (p_turn)
    else $error("turnaround left transmit active");
  property p_idle; !line_driver_enable |-> !serial_tx_enable && !tx_byte_load; endproperty
  a_idle: assert property (p_idle)
    else $error("transmit activity while receiving");
endmodule

//--- testbench/rtf_serial_model.sv
/* Serial port model: raises transmit requests and the end event.
   Assumes the block's enable levels; gaps alternate fast and slow. */
`timescale 1ns/1ps
module rtf_serial_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Enables from the block, events to it
  input  wire logic transmit_ready_enable,
  input  wire logic transmit_end_enable,
  output logic      transmit_ready_request,
  output logic      transmit_end_event
);
  logic [3:0] gap;
  logic       slow;
  // Pulse one event per gap; a slow gap stresses the pending request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 4'h0;
      slow <= 1'b0;
      transmit_ready_request <= 1'b0;
      transmit_end_event <= 1'b0;
    end else begin
      transmit_ready_request <= 1'b0;
      transmit_end_event <= 1'b0;
      if (gap != 4'h0) begin
        gap <= gap - 4'h1;
      end else if (transmit_ready_enable || transmit_end_enable) begin
        transmit_ready_request <= transmit_ready_enable;
        transmit_end_event <= transmit_end_enable && !transmit_ready_enable;
        slow <= ~slow;
        gap <= slow ? 4'h9 : 4'h3;
      end
    end
  end
endmodule

//--- testbench/test_rtf_frame_ctrl.sv
/* Self-checking bench: frames in, register reads, response bytes out.
   Assumes the serial model answers transmit enables. */
`timescale 1ns/1ps
module test_rtf_frame_ctrl;
  import rtf_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        rxr, trr, tee, ld, ste, tre, tende, lde, ren;
  logic [7:0]  rx_byte, tx_byte, rs;
  logic [15:0] c, tc;
  logic [32:0] rq[$], tq[$];
  logic [31:0] mq[$];
  int          failures, check_count;
  logic [7:0]  ta[5] = '{8'h01, 8'h02, 8'h00, 8'h01, 8'h01};
  logic [7:0]  tf[5] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h05};
  logic [2:0]  tv[5] = '{3'h5, 3'h1, 3'h2, 3'h3, 3'h4};
  rtf_frame_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .receive_byte_request(rxr), .rx_byte(rx_byte),
    .transmit_ready_request(trr), .transmit_end_event(tee), .tx_byte(tx_byte),
    .tx_byte_load(ld), .serial_tx_enable(ste), .transmit_ready_enable(tre),
    .transmit_end_enable(tende), .line_driver_enable(lde), .receiver_enable_n(ren));
  rtf_serial_model u_sp (.pclk(pclk), .presetn(presetn), .transmit_ready_enable(tre),
    .transmit_end_enable(tende), .transmit_ready_request(trr), .transmit_end_event(tee));
  ////////////////////////////////////////
  function automatic logic [15:0] crc(input logic [15:0] v, input logic [7:0] d);
    v ^= {8'h00, d};
    repeat (8) v = v[0] ? ((v >> 1) ^ CRC_POLY_REFL) : (v >> 1);
    return v;
  endfunction
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task chk(input string n, input logic [32:0] s, input logic [32:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // APB master: holds the request until pready is sampled high
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [32:0] e);
    mq.push_back(m); rq.push_back(e); xfer(1'b0, a, 32'h0);
  endtask
  task rxb(input logic [7:0] b);
    @(posedge pclk); rxr <= 1'b1; rx_byte <= b;
    @(posedge pclk); rxr <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task tpush(input logic [7:0] b);
    tq.push_back({25'h0, b}); tc = crc(tc, b);
  endtask
  // Clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Monitor: oldest note against each result
  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0 && rq.size() > 0)
      chk("apb read", {pslverr, prdata & mq.pop_front()}, rq.pop_front());
    if (ld === 1'b1)
      chk("tx_byte", {25'h0, tx_byte}, tq.size() > 0 ? tq.pop_front() : 33'h1ffff);
  end
  // Watchdog
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    close_out();
  end
  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; rxr = 1'b0; rx_byte = 8'h00; rs = 8'h1e; failures = 0; check_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_STATION, 32'hff, {25'h0, STATION_RST});
    rd(OFS_SIL_A, 32'hffff, {17'h0, SIL_A_RST});
    rd(12'h020, 32'hffffffff, 33'h1_0000_0000);
    xfer(1'b1, OFS_SIL_A, 32'h2); xfer(1'b1, OFS_SIL_B, 32'h2); xfer(1'b1, OFS_FUNC_MASK, 32'h8);
    for (int i = 0; i < 5; i++) begin
      c = crc(crc(CRC_INIT, ta[i]), tf[i]);
      tc = CRC_INIT;
      if (tv[i] == 3'h4) begin
        tpush(ta[i]); tpush(tf[i] | EXC_FLAG); tpush(EXC_ILLEGAL_FN);
        tq.push_back({25'h0, tc[7:0]}); tq.push_back({25'h0, tc[15:8]});
      end
      rxb(ta[i]); rxb(tf[i]); rxb(c[7:0] ^ {7'h0, i == 3}); rxb(c[15:8]);
      repeat (160) @(posedge pclk);
      rd(OFS_RX_COUNT, 32'hffffffff, 33'h0_8000_0004);
      rd(OFS_RX_COUNT, 32'hffffffff, 33'h0);
      rd(OFS_STATUS, 32'h7, {30'h0, tv[i]});
      if (tv[i] == 3'h5) begin
        rd(12'h400, 32'hff, {25'h0, ta[i]});
        rs = lfsr(rs);
        tpush(rs);
        tq.push_back({25'h0, tc[7:0]}); tq.push_back({25'h0, tc[15:8]});
        xfer(1'b1, OFS_TX_LEN, 32'h1); xfer(1'b1, 12'h800, {24'h0, rs});
      end
      xfer(1'b1, OFS_CTRL, 32'h1);
      repeat (5) @(posedge pclk);
      for (int k = 0; k < 3000 && lde !== 1'b0; k++) @(posedge pclk);
      chk("tx left", {lde, 32'(tq.size())}, 33'h0);
      $display("test %0d done", i);
    end
    close_out();
  end
endmodule
bind rtf_frame_ctrl rtf_frame_chk u_chk (.pclk(pclk), .presetn(presetn),
  .transmit_end_event(transmit_end_event), .tx_byte_load(tx_byte_load),
  .serial_tx_enable(serial_tx_enable), .transmit_ready_enable(transmit_ready_enable),
  .transmit_end_enable(transmit_end_enable), .line_driver_enable(line_driver_enable),
  .receiver_enable_n(receiver_enable_n));
